// ### core/etpc_pkg.sv
// etpc_pkg: register map, field positions, reset values and types of the event timer
package etpc_pkg;

	// ********************************************************
	// register map (byte addresses, one 32-bit word each)
	// ********************************************************
	localparam logic [3:0] ADDR_MODE_CTL = 4'h0;
	localparam logic [3:0] ADDR_PRELOAD  = 4'h4;
	localparam logic [3:0] ADDR_IRQ_CTL  = 4'h8;
	localparam logic [3:0] ADDR_COUNT    = 4'hc;

	// ********************************************************
	// mode_ctl fields
	// ********************************************************
	localparam int MODE_HI     = 7;
	localparam int MODE_LO     = 6;
	localparam int RUN_POS     = 4;
	localparam int EDGE_POS    = 3;
	localparam int DIV_HI      = 2;
	localparam logic [7:0] MODE_CTL_WMASK = 8'hdf;
	localparam logic [7:0] MODE_CTL_RESET = 8'h08;

	// ********************************************************
	// irq_ctl fields
	// ********************************************************
	localparam int GIE_POS      = 0;
	localparam int OVF_ON_POS   = 1;
	localparam int TICK_ON_POS  = 2;
	localparam int OVF_FLAG_POS = 4;
	localparam int TICK_FLG_POS = 5;
	localparam logic [7:0] IRQ_CTL_WMASK = 8'h37;
	localparam logic [7:0] IRQ_CTL_RESET = 8'h00;
	localparam logic [7:0] PRELOAD_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] COUNT_FULL    = 8'hff;
	localparam logic [31:0] UNMAPPED_RD  = 32'h0000_0000;

	typedef enum logic [1:0] {
		ETPC_MODE_UNUSED = 2'h0,
		ETPC_MODE_EVENT  = 2'h1,
		ETPC_MODE_TIMER  = 2'h2,
		ETPC_MODE_PULSE  = 2'h3
	} etpc_mode_t;

	typedef enum logic [1:0] {
		ETPC_PW_IDLE,
		ETPC_PW_ARMED,
		ETPC_PW_COUNT
	} etpc_pw_state_t;

	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} etpc_av_req_t;

endpackage : etpc_pkg

// ### core/etpc_prescaler.sv
// etpc_prescaler: divides the low-speed oscillator and marks falling edges of the chosen tap
`timescale 1ns/1ps
`default_nettype none

module etpc_prescaler (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       low_speed_osc,
	input  wire logic [2:0] clk_div_sel,
	output var  logic       tick
);

	// ********************************************************
	// oscillator edge detection and divider
	// ********************************************************
	logic       osc_d;
	logic [6:0] div_cnt;
	logic [7:0] taps;
	logic [7:0] taps_d;
	logic       osc_fall;

	assign osc_fall = osc_d & ~low_speed_osc;
	assign taps     = {div_cnt, low_speed_osc};

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			osc_d   <= 1'b0;
			div_cnt <= 7'h00;
			taps_d  <= 8'h00;
		end else begin
			osc_d   <= low_speed_osc;
			taps_d  <= taps;
			if (osc_fall)
				div_cnt <= div_cnt + 7'h01;
		end
	end

	// counting happens on the high-to-low transition of the selected tap
	genvar gi;
	logic [7:0] tap_fall;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_tap
			assign tap_fall[gi] = taps_d[gi] & ~taps[gi];
		end
	endgenerate

	assign tick = tap_fall[clk_div_sel];

endmodule : etpc_prescaler

`default_nettype wire

// ### core/etpc_top.sv
// etpc_top: 8-bit timer / event counter / pulse width capture with Avalon-MM registers
// Functional notes
// - mode field: 01 event count, 10 timed count, 11 pulse capture, 00 unused
// - run_bit at bit 4 enables counting when one
// - event mode counts rising edges if edge_sel zero, falling if one
// - pulse mode: edge_sel one measures high pulse, zero measures low pulse
// - prescaler divides oscillator by two to the clk_div_sel power
// - eight-bit preload register, resets to zero
// - timed mode increments on each falling edge of prescaled clock
// - overflow sets request flag, reloads from preload, keeps counting
// - event counting continues in idle or sleep; overflow also wakes when the overflow flag was clear
// - pulse mode: run_bit only arms; counting starts on active edge
// - pulse mode: return to prior level stops count and clears run_bit
// - timed and event modes: run_bit changes only by software write
// - pulse mode counter is clocked by prescaled internal clock
// - irq_ctl bit 4 overflow flag, bit 5 tick flag, both writable
// - irq_ctl bit 0 global, bit 1 overflow, bit 2 tick enables
// - unimplemented bits read zero: irq_ctl 7,6,3 and mode_ctl 5
// - timed and event modes count up and overflow after all ones
// - preload write with run_bit clear also loads counter
// - count read returns count; counting held off during the read
// - finished measurement held until run_bit set again
`timescale 1ns/1ps
`default_nettype none

module etpc_top (
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	input  wire logic        low_speed_osc,
	input  wire logic        ext_clk_pin,
	input  wire logic        tick_event,
	output var  logic        ovf_irq_req,
	output var  logic        tick_irq_req,
	output var  logic        wake_up
);

	// ********************************************************
	// bus decode
	// ********************************************************
	etpc_pkg::etpc_av_req_t req;
	logic                   acked;
	logic                   take;
	logic                   wr_mode;
	logic                   wr_pre;
	logic                   wr_irq;
	logic                   rd_cnt;

	assign req   = '{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable};
	// one wait cycle: the request is taken on the edge where waitrequest is seen low
	assign take    = (req.read | req.write) & ~avs_waitrequest;
	assign wr_mode = take & req.write & req.byteenable[0]
		& (req.address == etpc_pkg::ADDR_MODE_CTL);
	assign wr_pre  = take & req.write & req.byteenable[0]
		& (req.address == etpc_pkg::ADDR_PRELOAD);
	assign wr_irq  = take & req.write & req.byteenable[0]
		& (req.address == etpc_pkg::ADDR_IRQ_CTL);
	// the whole read window, not just the taking edge, blocks counting
	assign rd_cnt  = req.read & (req.address == etpc_pkg::ADDR_COUNT);

	// ********************************************************
	// registers and counting state
	// ********************************************************
	logic [7:0]               mode_ctl;
	logic [7:0]               preload_value;
	logic [7:0]               irq_ctl;
	logic [7:0]               count;
	etpc_pkg::etpc_pw_state_t pw_state;
	etpc_pkg::etpc_pw_state_t next_pw_state;
	logic                     pin_s1;
	logic                     pin_s2;
	logic                     pin_s3;
	logic                     tick;
	logic                     ovf_irq_flag;
	logic                     tick_irq_flag;

	logic [1:0] op_mode_sel;
	logic       run_bit;
	logic       edge_sel;
	logic [2:0] clk_div_sel;
	assign op_mode_sel = mode_ctl[etpc_pkg::MODE_HI:etpc_pkg::MODE_LO];
	assign run_bit     = mode_ctl[etpc_pkg::RUN_POS];
	assign edge_sel    = mode_ctl[etpc_pkg::EDGE_POS];
	assign clk_div_sel = mode_ctl[etpc_pkg::DIV_HI:0];
	assign ovf_irq_flag  = irq_ctl[etpc_pkg::OVF_FLAG_POS];
	assign tick_irq_flag = irq_ctl[etpc_pkg::TICK_FLG_POS];

	etpc_prescaler u_presc (
		.mclk          (mclk),
		.rst_b         (rst_b),
		.low_speed_osc (low_speed_osc),
		.clk_div_sel   (clk_div_sel),
		.tick          (tick)
	);

	// ********************************************************
	// pin synchroniser and edge detection
	// ********************************************************
	logic pin_rise;
	logic pin_fall;
	assign pin_rise = pin_s2 & ~pin_s3;
	assign pin_fall = ~pin_s2 & pin_s3;

	logic is_event;
	logic is_timer;
	logic is_pulse;
	assign is_event = (op_mode_sel == etpc_pkg::ETPC_MODE_EVENT);
	assign is_timer = (op_mode_sel == etpc_pkg::ETPC_MODE_TIMER);
	assign is_pulse = (op_mode_sel == etpc_pkg::ETPC_MODE_PULSE);

	logic ev_edge;
	logic pw_start;
	logic pw_stop;
	assign ev_edge  = edge_sel ? pin_fall : pin_rise;
	assign pw_start = edge_sel ? pin_rise : pin_fall;
	assign pw_stop  = edge_sel ? pin_fall : pin_rise;

	// ********************************************************
	// pulse capture sequencer
	// ********************************************************
	always_comb begin
		next_pw_state = pw_state;
		unique case (pw_state)
			etpc_pkg::ETPC_PW_IDLE:
				if (is_pulse && run_bit)
					next_pw_state = etpc_pkg::ETPC_PW_ARMED;
			etpc_pkg::ETPC_PW_ARMED:
				if (!is_pulse || !run_bit)
					next_pw_state = etpc_pkg::ETPC_PW_IDLE;
				else if (pw_start)
					next_pw_state = etpc_pkg::ETPC_PW_COUNT;
			etpc_pkg::ETPC_PW_COUNT:
				if (!is_pulse || !run_bit || pw_stop)
					next_pw_state = etpc_pkg::ETPC_PW_IDLE;
			default:
				next_pw_state = etpc_pkg::ETPC_PW_IDLE;
		endcase
	end

	logic pw_done;
	assign pw_done = (pw_state == etpc_pkg::ETPC_PW_COUNT) & is_pulse & run_bit & pw_stop;

	// ********************************************************
	// counter step
	// ********************************************************
	logic cnt_step;
	logic ovf;
	assign cnt_step = run_bit & ~rd_cnt & (
		(is_timer & tick) |
		(is_event & ev_edge) |
		(is_pulse & tick & (pw_state == etpc_pkg::ETPC_PW_COUNT) & ~pw_stop));
	assign ovf = cnt_step & (count == etpc_pkg::COUNT_FULL);

	logic [7:0] next_count;
	assign next_count = ovf ? preload_value
		: cnt_step ? count + 8'h01
		: (wr_pre && !run_bit) ? req.writedata[7:0]
		: count;

	// software write of run_bit; hardware clears it only at end of a pulse
	logic [7:0] next_mode_ctl;
	assign next_mode_ctl = wr_mode ? (req.writedata[7:0] & etpc_pkg::MODE_CTL_WMASK)
		: pw_done ? (mode_ctl & ~(8'h01 << etpc_pkg::RUN_POS))
		: mode_ctl;

	// flag set wins over a simultaneous software clear
	logic [7:0] irq_wr;
	logic [7:0] next_irq_ctl;
	logic       tick_set;
	assign tick_set = tick_event & ~tick_irq_flag;
	assign irq_wr = wr_irq ? (req.writedata[7:0] & etpc_pkg::IRQ_CTL_WMASK)
		: irq_ctl;
	assign next_irq_ctl = irq_wr
		| ({7'h00, ovf} << etpc_pkg::OVF_FLAG_POS)
		| ({7'h00, tick_event} << etpc_pkg::TICK_FLG_POS);

	logic [31:0] rd_mux;
	assign rd_mux =
		(req.address == etpc_pkg::ADDR_MODE_CTL) ? {24'h0, mode_ctl} :
		(req.address == etpc_pkg::ADDR_PRELOAD)  ? {24'h0, preload_value} :
		(req.address == etpc_pkg::ADDR_IRQ_CTL)  ? {24'h0, irq_ctl} :
		(req.address == etpc_pkg::ADDR_COUNT)    ? {24'h0, count} :
		etpc_pkg::UNMAPPED_RD;

	// ********************************************************
	// state flip-flops
	// ********************************************************
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			mode_ctl        <= etpc_pkg::MODE_CTL_RESET;
			preload_value   <= etpc_pkg::PRELOAD_RESET;
			irq_ctl         <= etpc_pkg::IRQ_CTL_RESET;
			count           <= etpc_pkg::COUNT_RESET;
			pw_state        <= etpc_pkg::ETPC_PW_IDLE;
			pin_s1          <= 1'b0;
			pin_s2          <= 1'b0;
			pin_s3          <= 1'b0;
			acked           <= 1'b0;
			avs_readdata    <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
			ovf_irq_req     <= 1'b0;
			tick_irq_req    <= 1'b0;
			wake_up         <= 1'b0;
		end else begin
			pin_s1          <= ext_clk_pin;
			pin_s2          <= pin_s1;
			pin_s3          <= pin_s2;
			mode_ctl        <= next_mode_ctl;
			irq_ctl         <= next_irq_ctl;
			count           <= next_count;
			pw_state        <= next_pw_state;
			if (wr_pre)
				preload_value <= req.writedata[7:0];
			acked           <= take;
			avs_waitrequest <= ~((req.read | req.write) & avs_waitrequest & ~acked);
			if ((req.read | req.write) & avs_waitrequest & ~acked)
				avs_readdata <= rd_mux;
			ovf_irq_req  <= next_irq_ctl[etpc_pkg::GIE_POS]
				& next_irq_ctl[etpc_pkg::OVF_ON_POS] & next_irq_ctl[etpc_pkg::OVF_FLAG_POS];
			tick_irq_req <= next_irq_ctl[etpc_pkg::GIE_POS]
				& next_irq_ctl[etpc_pkg::TICK_ON_POS] & next_irq_ctl[etpc_pkg::TICK_FLG_POS];
			// wake when an overflow or tick event sets a clear request flag (not on a software write), enables ignored
			wake_up <= (ovf & ~ovf_irq_flag) | tick_set;
		end
	end

	// ********************************************************
	// assertions
	// ********************************************************
	property p_ovf_reload;
		@(posedge mclk) disable iff (!rst_b)
		ovf |=> (count == $past(preload_value)) && irq_ctl[etpc_pkg::OVF_FLAG_POS];
	endproperty
	a_ovf_reload: assert property (p_ovf_reload) else $error("overflow did not reload");

	property p_step;
		@(posedge mclk) disable iff (!rst_b)
		(cnt_step && count != etpc_pkg::COUNT_FULL) |=> count == $past(count) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count did not step");

	property p_stopped;
		@(posedge mclk) disable iff (!rst_b)
		(!run_bit && !wr_pre) |=> count == $past(count);
	endproperty
	a_stopped: assert property (p_stopped) else $error("count moved while stopped");

	property p_read_hold;
		@(posedge mclk) disable iff (!rst_b)
		(rd_cnt && !wr_pre) |=> count == $past(count);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("count moved during read");

	property p_run_kept;
		@(posedge mclk) disable iff (!rst_b)
		(!is_pulse && !wr_mode && run_bit) |=> run_bit;
	endproperty
	a_run_kept: assert property (p_run_kept) else $error("run bit cleared by hardware");

	property p_pw_end;
		@(posedge mclk) disable iff (!rst_b)
		(pw_done && !wr_mode) |=> !run_bit && pw_state == etpc_pkg::ETPC_PW_IDLE;
	endproperty
	a_pw_end: assert property (p_pw_end) else $error("pulse end did not clear run");

	property p_armed_idle;
		@(posedge mclk) disable iff (!rst_b)
		(pw_state == etpc_pkg::ETPC_PW_ARMED && is_pulse) |-> !cnt_step;
	endproperty
	a_armed_idle: assert property (p_armed_idle) else $error("counted before active edge");

	property p_preload_load;
		@(posedge mclk) disable iff (!rst_b)
		(wr_pre && !run_bit) |=> count == $past(req.writedata[7:0]);
	endproperty
	a_preload_load: assert property (p_preload_load) else $error("stopped preload lost");

	property p_rsvd;
		@(posedge mclk) disable iff (!rst_b)
		(irq_ctl[7:6] == 2'h0) && !irq_ctl[3] && !mode_ctl[5];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

	property p_ack;
		@(posedge mclk) disable iff (!rst_b)
		$rose(req.read | req.write) |=> !avs_waitrequest;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");

	c_ovf:   cover property (@(posedge mclk) disable iff (!rst_b) ovf);
	c_pw:    cover property (@(posedge mclk) disable iff (!rst_b) pw_done);
	c_event: cover property (@(posedge mclk) disable iff (!rst_b) is_event && cnt_step);
	c_wake:  cover property (@(posedge mclk) disable iff (!rst_b) wake_up);

endmodule : etpc_top

`default_nettype wire

// ### test/etpc_pin_src.sv
// etpc_pin_src: external signal source toggling the shared event pin on request
`timescale 1ns/1ps
`default_nettype none

module etpc_pin_src (
	input  wire logic       mclk,
	input  wire logic       rst_b,
	input  wire logic       go,
	input  wire logic [3:0] n_tog,
	input  wire logic [7:0] gap,
	output var  logic       pin,
	output var  logic       busy
);
	logic [3:0] left;
	logic [7:0] wait_cnt;

	// the pin is a plain input level to the timer, idle low until asked to move
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			pin      <= 1'b0;
			busy     <= 1'b0;
			left     <= 4'h0;
			wait_cnt <= 8'h00;
		end else if (go && !busy) begin
			busy     <= 1'b1;
			left     <= n_tog;
			wait_cnt <= gap;
		end else if (busy) begin
			if (wait_cnt != 8'h00) begin
				wait_cnt <= wait_cnt - 8'h01;
			end else if (left == 4'h0) begin
				busy <= 1'b0;
			end else begin
				pin      <= ~pin;
				left     <= left - 4'h1;
				wait_cnt <= gap;
			end
		end
	end
endmodule : etpc_pin_src
`default_nettype wire

// ### test/etpc_top_tb.sv
// etpc_top_tb: register-level tests of the event timer over its Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none

module etpc_top_tb;
	localparam logic [3:0] A_MODE = etpc_pkg::ADDR_MODE_CTL;
	localparam logic [3:0] A_PRE  = etpc_pkg::ADDR_PRELOAD;
	localparam logic [3:0] A_IRQ  = etpc_pkg::ADDR_IRQ_CTL;
	localparam logic [3:0] A_CNT  = etpc_pkg::ADDR_COUNT;

	logic                   mclk;
	logic                   rst_b;
	etpc_pkg::etpc_av_req_t req;
	logic [31:0]            rdata;
	logic                   wreq;
	logic [2:0]             osc_div;
	logic                   tick_ev;
	logic                   go;
	logic [3:0]             n_tog;
	logic [7:0]             gap;
	logic                   pin;
	logic                   busy;
	logic                   ovf_req;
	logic                   tick_req;
	logic                   wake;
	logic [7:0]             q;
	logic [7:0]             c;
	logic [7:0]             cfg;
	logic [3:0]             be;
	int                     miscompares = 0;
	int                     cmp_count = 0;
	int                     wakes = 0;
	int                     w0;
	int                     t;

	etpc_top i_etpc_top (
		.mclk(mclk), .rst_b(rst_b), .avs_address(req.address), .avs_read(req.read),
		.avs_write(req.write), .avs_writedata(req.writedata),
		.avs_byteenable(req.byteenable), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.low_speed_osc(osc_div[2]), .ext_clk_pin(pin), .tick_event(tick_ev),
		.ovf_irq_req(ovf_req), .tick_irq_req(tick_req), .wake_up(wake)
	);

	etpc_pin_src i_etpc_pin_src (
		.mclk(mclk), .rst_b(rst_b), .go(go), .n_tog(n_tog), .gap(gap), .pin(pin), .busy(busy)
	);

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	// oscillator at one eighth of mclk, so one prescaled tick per 8 cycles at divide by 1
	always @(posedge mclk) osc_div <= osc_div + 3'h1;
	always @(posedge mclk) if (wake === 1'b1) wakes <= wakes + 1;

	// ********************************************************
	// access and compare tasks
	// ********************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// request held until waitrequest is seen low; a dead slave counts as a mismatch
	task automatic acc(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		req <= '{address: a, read: !w, write: w, writedata: {24'h0, d}, byteenable: be};
		do begin
			@(posedge mclk);
			n++;
		end while (wreq !== 1'b0 && n < 100);
		if (n >= 100) check(8'h00, 8'h01);
		q = rdata[7:0];
		if (!w && rdata[31:8] !== 24'h0) check(8'h00, 8'h01);
		req.read  <= 1'b0;
		req.write <= 1'b0;
		@(posedge mclk);
	endtask : acc

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		acc(a, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		acc(a, 1'b0, 8'h00);
		check(q, exp);
	endtask : rd

	// request lines are registered, so let two edges pass before looking
	task automatic irq_chk(input logic [1:0] exp);
		repeat (2) @(posedge mclk);
		check({6'h0, tick_req, ovf_req}, {6'h0, exp});
	endtask : irq_chk

	task automatic pins(input logic [3:0] n, input logic [7:0] g);
		int k;
		k = 0;
		go    <= 1'b1;
		n_tog <= n;
		gap   <= g;
		@(posedge mclk);
		go <= 1'b0;
		do begin
			@(posedge mclk);
			k++;
		end while (busy === 1'b1 && k < 3000);
		if (k >= 3000) check(8'h00, 8'h01);
		repeat (4) @(posedge mclk);
	endtask : pins

	task automatic end_of_test;
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		end_of_test();
	end

	// ********************************************************
	// tests
	// ********************************************************
	initial begin
		rst_b   = 1'b0;
		req     = '0;
		be      = 4'hf;
		osc_div = 3'h0;
		tick_ev = 1'b0;
		go      = 1'b0;
		n_tog   = 4'h0;
		gap     = 8'h00;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		rd(A_MODE, 8'h08);
		rd(A_PRE, 8'h00);
		rd(A_IRQ, 8'h00);
		rd(A_CNT, 8'h00);
		rd(4'h2, 8'h00);
		wr(A_MODE, 8'hef);
		rd(A_MODE, 8'hcf);
		wr(A_PRE, 8'ha5);
		rd(A_PRE, 8'ha5);
		rd(A_CNT, 8'ha5);
		wr(A_CNT, 8'h3c);
		rd(A_CNT, 8'ha5);
		// a write with lane 0 disabled must leave the register alone
		be = 4'h0;
		wr(A_PRE, 8'h77);
		be = 4'hf;
		rd(A_PRE, 8'ha5);
		rd(A_CNT, 8'ha5);
		wr(A_IRQ, 8'hff);
		rd(A_IRQ, 8'h37);
		irq_chk(2'b11);
		wr(A_IRQ, 8'h36);
		irq_chk(2'b00);
		wr(A_IRQ, 8'h05);
		tick_ev <= 1'b1;
		@(posedge mclk);
		tick_ev <= 1'b0;
		rd(A_IRQ, 8'h25);
		irq_chk(2'b10);
		wr(A_IRQ, 8'h00);
		$display("register test done");

		wr(A_MODE, 8'h40);
		wr(A_PRE, 8'hfe);
		rd(A_CNT, 8'hfe);
		wr(A_MODE, 8'h50);
		pins(4'h1, 8'h04);
		rd(A_CNT, 8'hff);
		pins(4'h1, 8'h04);
		rd(A_CNT, 8'hff);
		wr(A_PRE, 8'h20);
		rd(A_CNT, 8'hff);
		w0 = wakes;
		pins(4'h2, 8'h04);
		rd(A_CNT, 8'h20);
		rd(A_IRQ, 8'h10);
		check(8'(wakes - w0), 8'h01);
		rd(A_MODE, 8'h50);
		wr(A_MODE, 8'h58);
		pins(4'h1, 8'h04);
		rd(A_CNT, 8'h20);
		pins(4'h1, 8'h04);
		rd(A_CNT, 8'h21);
		wr(A_MODE, 8'h10);
		pins(4'h2, 8'h04);
		rd(A_CNT, 8'h21);
		$display("event test done");

		for (int d = 0; d < 8; d++) begin
			wr(A_MODE, 8'h80 | 8'(d));
			wr(A_PRE, 8'hfc);
			wr(A_IRQ, 8'h00);
			w0 = wakes;
			wr(A_MODE, 8'h90 | 8'(d));
			t = 0;
			while (wakes == w0 && t < 5000) begin
				@(posedge mclk);
				t++;
			end
			check(8'(t >= (24 << d) - 4 && t <= (32 << d) + 8), 8'h01);
			rd(A_MODE, 8'h90 | 8'(d));
			rd(A_IRQ, 8'h10);
		end
		$display("timer test done");

		// a high pulse first, then a low one; 81 cycles wide gives ten ticks of 8
		for (int e = 1; e >= 0; e--) begin
			if (e == 0) pins(4'h1, 8'h04);
			cfg = 8'hc0 | 8'(e << 3);
			wr(A_MODE, cfg);
			wr(A_PRE, 8'h00);
			wr(A_MODE, cfg | 8'h10);
			repeat (40) @(posedge mclk);
			rd(A_CNT, 8'h00);
			pins(4'h2, 8'h50);
			acc(A_CNT, 1'b0, 8'h00);
			c = q;
			check(8'(c >= 8'd9 && c <= 8'd11), 8'h01);
			rd(A_MODE, cfg);
			pins(4'h2, 8'h50);
			rd(A_CNT, c);
		end
		$display("pulse test done");
		end_of_test();
	end
endmodule : etpc_top_tb
`default_nettype wire
